// File: prf_physical_request_node_filter.sv
// Summary of operation
// - Low filter bit n lets physical requests from local node n use physical context.
// - Local physical-bound packets pass the async request filter first, then the physical bits.
// - Clear physical bit for the source node sends the request to async receive context.
// - Low filter set port at 118h, clear port at 11Ch, both on one store.
// - Reset clears every low filter bit.
// - Per-node check only for local bus; remote needs all-buses bit, kept over link reset.
`timescale 1ns/100ps
`include "prf_cfg.svh"

module prf_physical_request_node_filter
	import prf_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	// Wishbone classic slave
	input wire logic wbCycI,
	input wire logic wbStbI,
	input wire logic wbWeI,
	input wire logic [`PRF_ADDR_W-1:0] wbAdrI,
	input wire logic [`PRF_SEL_W-1:0] wbSelI,
	input wire prf_word_t wbDatI,
	output prf_word_t wbDatO,
	output logic wbAckO,
	// Link side
	input wire logic linkSoftReset,
	input wire prf_bus_id_t localBusId,
	// Receive path request
	input wire logic pktValid,
	input wire prf_bus_id_t pktSrcBusId,
	input wire prf_node_t pktSrcNodeId,
	input wire logic pktForPhys,
	input wire logic asyncFilterAccept,
	// Routing verdict
	output logic routeValid,
	output logic routePhysContext,
	output logic routeAsyncRequestReceiveContext,
	output logic routeReject,
	output logic acceptRemoteBusRequests
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Expands byte selects to a bit mask; used by both set and clear paths
	function automatic prf_word_t laneMask(input logic [`PRF_SEL_W-1:0] sel);
		prf_word_t mask;
		mask = `PRF_ZERO_WORD;
		for (int i = 0; i < `PRF_SEL_W; i++) begin
			mask[i*8 +: 8] = {8{sel[i]}};
		end
		return mask;
	endfunction : laneMask

	// Matches one register word; the low two address bits are ignored
	function automatic logic hitWord(input logic [`PRF_ADDR_W-1:0] adr,
		input logic [`PRF_ADDR_W-1:0] ofs);
		return adr[`PRF_ADDR_W-1:2] == ofs[`PRF_ADDR_W-1:2];
	endfunction : hitWord

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	prf_bus_state_e busState_q, busState_d;
	prf_word_t lowFilter_q, lowFilter_d;
	prf_high_nodes_t highNodes_q, highNodes_d;
	logic allBuses_q, allBuses_d;
	prf_word_t rdData_q, rdData_d;
	prf_route_e route_q, route_d;
	logic routeValid_q, routeValid_d;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic busReq;
	logic busCommit;
	logic hitLowSet;
	logic hitLowClr;
	logic hitHighSet;
	logic hitHighClr;
	prf_word_t wrMask;
	prf_word_t lowSetMask;
	prf_word_t lowClrMask;
	prf_word_t highSetMask;
	prf_word_t highClrMask;
	prf_word_t highWord;

	// A request is new while no ack is out; it commits on the ack edge
	assign busReq = wbCycI && wbStbI && (busState_q == PRF_BUS_IDLE);
	assign busCommit = wbCycI && wbStbI && wbWeI && (busState_q == PRF_BUS_ACK);
	assign hitLowSet = hitWord(wbAdrI, `PRF_OFS_LOW_SET);
	assign hitLowClr = hitWord(wbAdrI, `PRF_OFS_LOW_CLR);
	assign hitHighSet = hitWord(wbAdrI, `PRF_OFS_HIGH_SET);
	assign hitHighClr = hitWord(wbAdrI, `PRF_OFS_HIGH_CLR);

	// Only ones on enabled lanes act; zeros leave bits alone
	assign wrMask = wbDatI & laneMask(wbSelI);
	assign lowSetMask = (busCommit && hitLowSet) ? wrMask : `PRF_ZERO_WORD;
	assign lowClrMask = (busCommit && hitLowClr) ? wrMask : `PRF_ZERO_WORD;
	assign highSetMask = (busCommit && hitHighSet) ? wrMask : `PRF_ZERO_WORD;
	assign highClrMask = (busCommit && hitHighClr) ? wrMask : `PRF_ZERO_WORD;

	// Readback of the high word; unimplemented node bits read zero
	always_comb begin
		highWord = `PRF_ZERO_WORD;
		highWord[`PRF_HIGH_NODE_BITS-1:0] = highNodes_q;
		highWord[`PRF_ALL_BUSES_BIT] = allBuses_q;
	end

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------
	// Ack is held one cycle; the master must drop stb before the next
	always_comb begin
		case (busState_q)
			PRF_BUS_IDLE: busState_d = busReq ? PRF_BUS_ACK : PRF_BUS_IDLE;
			PRF_BUS_ACK: busState_d = PRF_BUS_IDLE;
			default: busState_d = PRF_BUS_IDLE;
		endcase
	end

	// Read data is captured with the request; unmapped offsets read zero
	assign rdData_d = !busReq ? rdData_q :
		(hitLowSet || hitLowClr) ? lowFilter_q :
		(hitHighSet || hitHighClr) ? highWord : `PRF_ZERO_WORD;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			busState_q <= PRF_BUS_IDLE;
			rdData_q <= `PRF_ZERO_WORD;
		end else begin
			busState_q <= busState_d;
			rdData_q <= rdData_d;
		end
	end

	assign wbAckO = (busState_q == PRF_BUS_ACK);
	assign wbDatO = rdData_q;

	// ------------------------------------------------------------------
	// Filter storage
	// ------------------------------------------------------------------
	// A software set in the same cycle as a clear or link reset wins,
	// so an enable written during a link reset is never lost
	assign lowFilter_d = (lowFilter_q & ~lowClrMask & ~{`PRF_WORD_W{linkSoftReset}})
		| lowSetMask;
	assign highNodes_d = (highNodes_q & ~highClrMask[`PRF_HIGH_NODE_BITS-1:0]
		& ~{`PRF_HIGH_NODE_BITS{linkSoftReset}})
		| highSetMask[`PRF_HIGH_NODE_BITS-1:0];
	// The all-buses bit ignores the link reset on purpose
	assign allBuses_d = (allBuses_q & ~highClrMask[`PRF_ALL_BUSES_BIT])
		| highSetMask[`PRF_ALL_BUSES_BIT];

	always_ff @(posedge core_clk) begin
		if (reset) begin
			lowFilter_q <= `PRF_RESET_LOW;
			highNodes_q <= `PRF_RESET_HIGH_NODES;
			allBuses_q <= `PRF_RESET_ALL_BUSES;
		end else begin
			lowFilter_q <= lowFilter_d;
			highNodes_q <= highNodes_d;
			allBuses_q <= allBuses_d;
		end
	end

	assign acceptRemoteBusRequests = allBuses_q;

	// ------------------------------------------------------------------
	// Routing decision
	// ------------------------------------------------------------------
	logic nodeEnabled;
	logic localSrc;

	prf_node_lookup u_lookup (
		.lowFilter(lowFilter_q),
		.highFilter(highNodes_q),
		.nodeId(pktSrcNodeId),
		.nodePhysicalEnableBit(nodeEnabled)
	);

	// The all-ones bus number always means this bus
	assign localSrc = (pktSrcBusId == localBusId) || (pktSrcBusId == `PRF_LOCAL_BUS_ALIAS);

	// For a local source the async filter is checked first, the physical bit second
	always_comb begin
		route_d = PRF_ROUTE_NONE;
		if (pktValid) begin
			if (!pktForPhys) begin
				route_d = asyncFilterAccept ? PRF_ROUTE_ASYNC : PRF_ROUTE_REJECT;
			end else if (!localSrc) begin
				route_d = allBuses_q ? PRF_ROUTE_PHYS : PRF_ROUTE_REJECT;
			end else if (!asyncFilterAccept) begin
				route_d = PRF_ROUTE_REJECT;
			end else if (nodeEnabled) begin
				route_d = PRF_ROUTE_PHYS;
			end else begin
				route_d = PRF_ROUTE_ASYNC;
			end
		end
	end

	assign routeValid_d = pktValid;

	// One verdict per request, one cycle after it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			route_q <= PRF_ROUTE_NONE;
			routeValid_q <= 1'b0;
		end else begin
			route_q <= route_d;
			routeValid_q <= routeValid_d;
		end
	end

	assign routeValid = routeValid_q;
	assign routePhysContext = (route_q == PRF_ROUTE_PHYS);
	assign routeAsyncRequestReceiveContext = (route_q == PRF_ROUTE_ASYNC);
	assign routeReject = (route_q == PRF_ROUTE_REJECT);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence lowSetWrite;
		busCommit && hitLowSet;
	endsequence

	sequence lowClrWrite;
		busCommit && hitLowClr && !linkSoftReset;
	endsequence

	sequence lowRead;
		busReq && !wbWeI && (hitLowSet || hitLowClr);
	endsequence

	sequence localPhysReq;
		pktValid && pktForPhys && localSrc && asyncFilterAccept;
	endsequence

	sequence highClrWrite;
		busCommit && hitHighClr;
	endsequence

	a_ack_answers_req: assert property (busReq |=> wbAckO ##1 !wbAckO)
		else $error("Ack did not follow request for exactly one cycle");

	a_low_set_sticks: assert property (lowSetWrite |=>
		((lowFilter_q & $past(lowSetMask)) == $past(lowSetMask)))
		else $error("Low set port did not set written ones");

	a_low_clr_works: assert property (lowClrWrite |=>
		((lowFilter_q & $past(lowClrMask)) == `PRF_ZERO_WORD))
		else $error("Low clear port did not clear written ones");

	a_low_read_value: assert property (lowRead |=>
		(wbAckO && wbDatO == $past(lowFilter_q)))
		else $error("Low filter readback mismatch");

	a_reset_clears_low: assert property ($fell(reset) |->
		(lowFilter_q == `PRF_RESET_LOW && !allBuses_q))
		else $error("Low filter not clear after reset");

	a_soft_keeps_all: assert property ((linkSoftReset && !busCommit) |=>
		(allBuses_q == $past(allBuses_q) && lowFilter_q == `PRF_ZERO_WORD))
		else $error("Link reset handled all-buses or node bits wrongly");

	a_clear_goes_async: assert property ((localPhysReq and !nodeEnabled) |=>
		(routeValid && routeAsyncRequestReceiveContext))
		else $error("Disabled node not sent to async context");

	a_set_goes_phys: assert property ((localPhysReq and nodeEnabled) |=>
		(routeValid && routePhysContext))
		else $error("Enabled node not sent to physical context");

	a_async_first: assert property ((pktValid && pktForPhys && localSrc
		&& !asyncFilterAccept) |=> routeReject)
		else $error("Async filter reject overridden");

	a_remote_needs_all: assert property ((pktValid && pktForPhys && !localSrc)
		|=> (routePhysContext == $past(allBuses_q) && routeReject != $past(allBuses_q)))
		else $error("Remote bus request routed against all-buses bit");

	a_high_node_map: assert property ((localPhysReq and
		(pktSrcNodeId >= `PRF_HIGH_NODE_BASE && pktSrcNodeId <= `PRF_HIGH_NODE_LAST))
		|=> (routePhysContext == $past(nodeEnabled)))
		else $error("High node routed against its filter bit");

	// Nodes past the high filter have no bit, so their local requests must never reach the physical side
	a_far_node_async: assert property ((localPhysReq and
		(pktSrcNodeId > `PRF_HIGH_NODE_LAST))
		|=> routeAsyncRequestReceiveContext)
		else $error("Node without a filter bit not sent to async context");

	// Reserved bits read zero, so the whole word must be clear where ones were written
	a_high_clr_works: assert property (highClrWrite |=>
		((highWord & $past(highClrMask)) == `PRF_ZERO_WORD))
		else $error("High clear port did not clear written ones");

	a_one_verdict: assert property (routeValid |->
		$onehot({routePhysContext, routeAsyncRequestReceiveContext, routeReject}))
		else $error("Verdict did not name exactly one context");

	a_quiet_no_pkt: assert property (!pktValid |=>
		!(routeValid || routePhysContext || routeAsyncRequestReceiveContext
		|| routeReject))
		else $error("Verdict raised without a request");

	a_ack_only_req: assert property (!busReq |=> !wbAckO)
		else $error("Ack raised without a taken request");

endmodule : prf_physical_request_node_filter

// File: prf_cfg.svh
`ifndef PRF_CFG_SVH
`define PRF_CFG_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses on the Wishbone side)
// ----------------------------------------------------------------------
`define PRF_ADDR_W 12
`define PRF_OFS_HIGH_SET 12'h110
`define PRF_OFS_HIGH_CLR 12'h114
`define PRF_OFS_LOW_SET 12'h118
`define PRF_OFS_LOW_CLR 12'h11c

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define PRF_WORD_W 32
`define PRF_SEL_W 4
`define PRF_HIGH_NODE_BITS 17
`define PRF_ALL_BUSES_BIT 31
`define PRF_RESET_LOW 32'h0000_0000
`define PRF_RESET_HIGH_NODES 17'h0_0000
`define PRF_RESET_ALL_BUSES 1'h0
`define PRF_ZERO_WORD 32'h0000_0000

// ----------------------------------------------------------------------
// Node and bus numbering
// ----------------------------------------------------------------------
`define PRF_NODE_W 6
`define PRF_BUS_ID_W 10
`define PRF_LOW_NODE_LAST 6'h1f
`define PRF_HIGH_NODE_BASE 6'h20
`define PRF_HIGH_NODE_LAST 6'h30
`define PRF_LOCAL_BUS_ALIAS 10'h3ff

`endif

// File: prf_pkg.sv
`include "prf_cfg.svh"

package prf_pkg;

	// ------------------------------------------------------------------
	// Common types
	// ------------------------------------------------------------------
	typedef logic [`PRF_WORD_W-1:0] prf_word_t;
	typedef logic [`PRF_NODE_W-1:0] prf_node_t;
	typedef logic [`PRF_BUS_ID_W-1:0] prf_bus_id_t;
	typedef logic [`PRF_HIGH_NODE_BITS-1:0] prf_high_nodes_t;

	// Bus slave states, one-hot
	typedef enum logic [1:0] {
		PRF_BUS_IDLE = 2'h1,
		PRF_BUS_ACK = 2'h2
	} prf_bus_state_e;

	// Routing verdict, one-hot
	typedef enum logic [3:0] {
		PRF_ROUTE_NONE = 4'h1,
		PRF_ROUTE_PHYS = 4'h2,
		PRF_ROUTE_ASYNC = 4'h4,
		PRF_ROUTE_REJECT = 4'h8
	} prf_route_e;

endpackage : prf_pkg

// File: prf_node_lookup.sv
`timescale 1ns/100ps
`include "prf_cfg.svh"

module prf_node_lookup
	import prf_pkg::*;
(
	input wire prf_word_t lowFilter,
	input wire prf_high_nodes_t highFilter,
	input wire prf_node_t nodeId,
	output logic nodePhysicalEnableBit
);

	// ------------------------------------------------------------------
	// Per-node lookup
	// ------------------------------------------------------------------
	// Nodes 49..62 and broadcast 63 have no bit here and read as disabled
	logic inLow;
	logic inHigh;
	prf_node_t highIndex;

	assign inLow = (nodeId <= `PRF_LOW_NODE_LAST);
	assign inHigh = (nodeId >= `PRF_HIGH_NODE_BASE) && (nodeId <= `PRF_HIGH_NODE_LAST);
	assign highIndex = nodeId - `PRF_HIGH_NODE_BASE;
	assign nodePhysicalEnableBit = inLow ? lowFilter[nodeId[4:0]] :
		(inHigh ? highFilter[highIndex[4:0]] : 1'b0);

endmodule : prf_node_lookup

// File: prf_remote_node.sv
`timescale 1ns/100ps
// ----------------------------------------
// Far-side node model: one request per call
// ----------------------------------------
module prf_remote_node
	import prf_pkg::*;
(
	input wire logic core_clk,
	output logic pktValid,
	output prf_bus_id_t pktSrcBusId,
	output prf_node_t pktSrcNodeId,
	output logic pktForPhys,
	output logic asyncFilterAccept
);
	// Fields of a stale request read as garbage, so a design that samples late is caught
	initial begin
		pktValid = 1'h0;
		pktSrcBusId = 10'h000;
		pktSrcNodeId = 6'h00;
		pktForPhys = 1'h0;
		asyncFilterAccept = 1'h0;
	end

	// One-cycle request; async filter verdict travels with it
	task automatic send(input prf_bus_id_t bus, input prf_node_t node, input logic phys,
			input logic acc);
		@(posedge core_clk);
		pktValid <= 1'h1;
		pktSrcBusId <= bus;
		pktSrcNodeId <= node;
		pktForPhys <= phys;
		asyncFilterAccept <= acc;
		@(posedge core_clk);
		pktValid <= 1'h0;
		pktSrcBusId <= ~bus;
		pktSrcNodeId <= ~node;
		pktForPhys <= ~phys;
		asyncFilterAccept <= ~acc;
	endtask : send
endmodule : prf_remote_node

// File: testbench.sv
`timescale 1ns/100ps
module testbench
	import prf_pkg::*;
;
	logic core_clk, reset, wbCycI, wbStbI, wbWeI, wbAckO, linkSoftReset;
	logic [11:0] wbAdrI;
	logic [3:0] wbSelI;
	prf_word_t wbDatI, wbDatO, rdData;
	logic pktValid, pktForPhys, asyncFilterAccept;
	prf_bus_id_t pktSrcBusId, localBusId;
	prf_node_t pktSrcNodeId;
	logic routeValid, routePhys, routeAsync, routeReject, acceptRemote;
	int numErrors = 0;
	int totalChecks = 0;
	int cycles = 0;

	prf_physical_request_node_filter dut (.core_clk(core_clk), .reset(reset),
		.wbCycI(wbCycI), .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
		.wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO), .linkSoftReset(linkSoftReset),
		.localBusId(localBusId), .pktValid(pktValid), .pktSrcBusId(pktSrcBusId),
		.pktSrcNodeId(pktSrcNodeId), .pktForPhys(pktForPhys),
		.asyncFilterAccept(asyncFilterAccept), .routeValid(routeValid),
		.routePhysContext(routePhys), .routeAsyncRequestReceiveContext(routeAsync),
		.routeReject(routeReject), .acceptRemoteBusRequests(acceptRemote));

	prf_remote_node node (.core_clk(core_clk), .pktValid(pktValid), .pktSrcBusId(pktSrcBusId),
		.pktSrcNodeId(pktSrcNodeId), .pktForPhys(pktForPhys),
		.asyncFilterAccept(asyncFilterAccept));

	// ----------------------------------------
	// Clock, timeout and verdict
	// ----------------------------------------
	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			numErrors++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results

	task automatic check(input prf_word_t seen, input prf_word_t exp);
		totalChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// ----------------------------------------
	// Wishbone classic master, waits for ack without assuming latency
	// ----------------------------------------
	task automatic wbCycle(input logic we, input logic [11:0] adr, input logic [3:0] sel,
			input prf_word_t dat);
		@(posedge core_clk);
		wbCycI <= 1'h1;
		wbStbI <= 1'h1;
		wbWeI <= we;
		wbAdrI <= adr;
		wbSelI <= sel;
		wbDatI <= dat;
		do @(posedge core_clk); while (wbAckO !== 1'h1);
		rdData = wbDatO;
		wbCycI <= 1'h0;
		wbStbI <= 1'h0;
	endtask : wbCycle

	task automatic rdCheck(input logic [11:0] adr, input prf_word_t exp);
		wbCycle(1'h0, adr, 4'hf, 32'h0000_0000);
		check(rdData, exp);
	endtask : rdCheck

	// Verdict code: valid=8, physical=4, async receive=2, reject=1
	task automatic route(input prf_bus_id_t bus, input prf_node_t n, input logic phys,
			input logic acc, input logic [3:0] exp);
		node.send(bus, n, phys, acc);
		#1;
		check({28'h0, routeValid, routePhys, routeAsync, routeReject}, {28'h0, exp});
	endtask : route

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		reset = 1'h1;
		{wbCycI, wbStbI, wbWeI, linkSoftReset} = 4'h0;
		wbAdrI = 12'h000;
		wbSelI = 4'h0;
		wbDatI = 32'h0000_0000;
		localBusId = 10'h005;
		repeat (12) @(posedge core_clk);
		reset <= 1'h0;
		rdCheck(12'h118, 32'h0000_0000);
		rdCheck(12'h110, 32'h0000_0000);
		wbCycle(1'h1, 12'h118, 4'hf, 32'h8000_0001);
		rdCheck(12'h11c, 32'h8000_0001);
		wbCycle(1'h1, 12'h118, 4'h1, 32'h0000_ff00);
		wbCycle(1'h1, 12'h11c, 4'hf, 32'h0000_0001);
		rdCheck(12'h118, 32'h8000_0000);
		route(10'h005, 6'h1f, 1'h1, 1'h1, 4'hc);
		route(10'h3ff, 6'h1f, 1'h1, 1'h1, 4'hc);
		route(10'h005, 6'h00, 1'h1, 1'h1, 4'ha);
		route(10'h005, 6'h1f, 1'h1, 1'h0, 4'h9);
		route(10'h005, 6'h00, 1'h0, 1'h1, 4'ha);
		wbCycle(1'h1, 12'h110, 4'hf, 32'h7ffe_0001);
		rdCheck(12'h114, 32'h0000_0001);
		wbCycle(1'h1, 12'h110, 4'hf, 32'h0001_0000);
		route(10'h005, 6'h20, 1'h1, 1'h1, 4'hc);
		route(10'h005, 6'h30, 1'h1, 1'h1, 4'hc);
		route(10'h005, 6'h21, 1'h1, 1'h1, 4'ha);
		route(10'h005, 6'h31, 1'h1, 1'h1, 4'ha);
		route(10'h006, 6'h1f, 1'h1, 1'h1, 4'h9);
		wbCycle(1'h1, 12'h110, 4'hf, 32'h8000_0000);
		// The bit lands at the ack edge, so look one edge later
		@(posedge core_clk);
		check({31'h0, acceptRemote}, 32'h0000_0001);
		route(10'h006, 6'h1f, 1'h1, 1'h1, 4'hc);
		rdCheck(12'h200, 32'h0000_0000);
		@(posedge core_clk);
		linkSoftReset <= 1'h1;
		@(posedge core_clk);
		linkSoftReset <= 1'h0;
		rdCheck(12'h110, 32'h8000_0000);
		rdCheck(12'h118, 32'h0000_0000);
		// Moving the local bus number turns bus 6 local and bus 5 remote
		localBusId <= 10'h006;
		route(10'h006, 6'h1f, 1'h1, 1'h1, 4'ha);
		route(10'h005, 6'h1f, 1'h1, 1'h1, 4'hc);
		wbCycle(1'h1, 12'h114, 4'hf, 32'h8000_0000);
		rdCheck(12'h110, 32'h0000_0000);
		check({31'h0, acceptRemote}, 32'h0000_0000);
		route(10'h005, 6'h1f, 1'h1, 1'h1, 4'h9);
		results();
	end
endmodule : testbench
